// ==== kvb_cfg.svh ====
`ifndef KVB_CFG_SVH
`define KVB_CFG_SVH
`define KVB_CLK_HZ         250000000
`define KVB_VIEW_S         90
// Over 32 bits at 250 MHz, so worked out in 64 bits
`define KVB_VIEW_CYC       (64'(`KVB_VIEW_S) * 64'(`KVB_CLK_HZ))
`define KVB_WARN_MS        500
`define KVB_WARN_CYC       (`KVB_WARN_MS * (`KVB_CLK_HZ / 1000))
`define KVB_RPT_HZ         20
`define KVB_RPT_CYC        (`KVB_CLK_HZ / `KVB_RPT_HZ)
`define KVB_CLICK_US       200
`define KVB_CLICK_CYC      (`KVB_CLICK_US * (`KVB_CLK_HZ / 1000000))
`define KVB_BELL_MS        500
`define KVB_BELL_CYC       (`KVB_BELL_MS * (`KVB_CLK_HZ / 1000))
`define KVB_TONE_HZ        1000
`define KVB_TONE_CYC       (`KVB_CLK_HZ / (2 * `KVB_TONE_HZ))
`define KVB_PWRUP_MS       100
`define KVB_PWRUP_CYC      (`KVB_PWRUP_MS * (`KVB_CLK_HZ / 1000))
`define KVB_WCNT_FULL      4'hf
`endif

// ==== kvb_ctrl.sv ====
// What this block does
// - Activity or key restarts viewing period
// - Blink lamp before dimming
// - Delay clears counter, stops warning pulses
// - Warning pulse trailing edge advances counter
// - Lamp from counter bit zero
// - Counter full dims, stops pulses, lamp off
// - Strobe follows raw strobe without repeat
// - Repeat plus key gives 10 Hz strobes
// - Toggle gates strobe at 10 Hz
// - Strobe falling edge gives 200 us click
// - Free tone gated by bell enable
// - Bell is one-shot, half second
// - Power-up asserts initial and origin 100 ms
// - Origin key asserts origin output
// - Edit mode never times out
// - Overbar signals are active low
`timescale 1ns/1ps
`include "kvb_cfg.svh"
`default_nettype none
module kvb_ctrl #(
  parameter longint unsigned VIEW_CYC = `KVB_VIEW_CYC,
  parameter int unsigned WARN_CYC  = `KVB_WARN_CYC,
  parameter int unsigned RPT_CYC   = `KVB_RPT_CYC,
  parameter int unsigned CLICK_CYC = `KVB_CLICK_CYC,
  parameter int unsigned BELL_CYC  = `KVB_BELL_CYC,
  parameter int unsigned TONE_CYC  = `KVB_TONE_CYC,
  parameter int unsigned PWRUP_CYC = `KVB_PWRUP_CYC
) (
  input  wire logic             clk,   // 250 MHz clock
  input  wire logic             rst_n, // Async reset, low
  input  wire kvb_pkg::kvb_in_s in_a,  // Asynchronous inputs
  output var  kvb_pkg::kvb_out_s out   // Registered outputs
);
  import kvb_pkg::*;
  localparam int NIN = $bits(kvb_in_s);

  logic [NIN-1:0] s1_r, s2_r, s3_r;
  kvb_in_s        sy, pv;
  // Two-stage sync, third stage only for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= in_a;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign sy = kvb_in_s'(s2_r);
  assign pv = kvb_in_s'(s3_r);

  // View/hold
  kvb_view_e   vst_r, vst_nxt;
  logic [35:0] vcnt_r, vcnt_nxt; // 90 s needs 35 bits
  logic [31:0] wtim_r, wtim_nxt;
  logic        wpulse_r, wpulse_nxt;
  logic [3:0]  wcnt_r, wcnt_nxt;
  logic        restart;
  assign restart = sy.data_activity | sy.watch_key | sy.watch_restart
                 | sy.edit_mode;
  always_comb begin
    vst_nxt    = vst_r;
    vcnt_nxt   = vcnt_r;
    wtim_nxt   = wtim_r;
    wpulse_nxt = wpulse_r;
    wcnt_nxt   = wcnt_r;
    if (restart) begin
      vst_nxt    = KVB_VIEWING;
      vcnt_nxt   = '0;
      wtim_nxt   = '0;
      wpulse_nxt = 1'b0;
      wcnt_nxt   = '0;
    end else begin
      case (vst_r)
        KVB_VIEWING: begin
          if (vcnt_r >= 36'(VIEW_CYC - 1)) vst_nxt = KVB_WARNING;
          else vcnt_nxt = vcnt_r + 36'h1;
        end
        KVB_WARNING: begin
          // Half-period toggle forms a pulse train
          if (wtim_r >= WARN_CYC - 1) begin
            wtim_nxt   = '0;
            wpulse_nxt = ~wpulse_r;
            if (wpulse_r) wcnt_nxt = wcnt_r + 4'h1;
          end else begin
            wtim_nxt = wtim_r + 32'h1;
          end
          if (wcnt_r == `KVB_WCNT_FULL) begin
            vst_nxt    = KVB_HOLDING;
            wpulse_nxt = 1'b0;
          end
        end
        KVB_HOLDING: wpulse_nxt = 1'b0;
        default:     vst_nxt = KVB_VIEWING;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vst_r    <= KVB_VIEWING;
      vcnt_r   <= '0;
      wtim_r   <= '0;
      wpulse_r <= 1'b0;
      wcnt_r   <= '0;
    end else begin
      vst_r    <= vst_nxt;
      vcnt_r   <= vcnt_nxt;
      wtim_r   <= wtim_nxt;
      wpulse_r <= wpulse_nxt;
      wcnt_r   <= wcnt_nxt;
    end
  end

  // Strobe, repeat and click
  logic [31:0] rtim_r, rtim_nxt;
  logic        gate_r, gate_nxt;
  logic        strb_r, strb_nxt;
  logic [31:0] ctim_r, ctim_nxt;
  logic        click_r, click_nxt;
  always_comb begin
    rtim_nxt  = rtim_r;
    gate_nxt  = gate_r;
    click_nxt = click_r;
    ctim_nxt  = ctim_r;
    // Free-running 20 Hz train; toggle halves it to 10 Hz
    if (rtim_r >= RPT_CYC - 1) begin
      rtim_nxt = '0;
      if (sy.autorepeat_key) gate_nxt = ~gate_r;
    end else begin
      rtim_nxt = rtim_r + 32'h1;
    end
    if (!sy.autorepeat_key) gate_nxt = 1'b0;
    strb_nxt = sy.key_press_strobe & ~gate_r;
    if (strb_r && !strb_nxt) begin
      click_nxt = 1'b1;
      ctim_nxt  = '0;
    end else if (click_r) begin
      if (ctim_r >= CLICK_CYC - 1) click_nxt = 1'b0;
      else ctim_nxt = ctim_r + 32'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rtim_r  <= '0;
      gate_r  <= 1'b0;
      strb_r  <= 1'b0;
      ctim_r  <= '0;
      click_r <= 1'b0;
    end else begin
      rtim_r  <= rtim_nxt;
      gate_r  <= gate_nxt;
      strb_r  <= strb_nxt;
      ctim_r  <= ctim_nxt;
      click_r <= click_nxt;
    end
  end

  // Bell tone
  logic [31:0] ttim_r, ttim_nxt;
  logic        tone_r, tone_nxt;
  logic [31:0] btim_r, btim_nxt;
  logic        bell_r, bell_nxt;
  logic        bell_rise;
  // Edge detect: a held command gives one burst
  assign bell_rise = (sy.bell_command & ~pv.bell_command)
                   | (sy.ring_command & ~pv.ring_command);
  always_comb begin
    ttim_nxt = ttim_r + 32'h1;
    tone_nxt = tone_r;
    if (ttim_r >= TONE_CYC - 1) begin
      ttim_nxt = '0;
      tone_nxt = ~tone_r;
    end
    btim_nxt = btim_r;
    bell_nxt = bell_r;
    if (bell_rise) begin
      bell_nxt = 1'b1;
      btim_nxt = '0;
    end else if (bell_r) begin
      if (btim_r >= BELL_CYC - 1) bell_nxt = 1'b0;
      else btim_nxt = btim_r + 32'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ttim_r <= '0;
      tone_r <= 1'b0;
      btim_r <= '0;
      bell_r <= 1'b0;
    end else begin
      ttim_r <= ttim_nxt;
      tone_r <= tone_nxt;
      btim_r <= btim_nxt;
      bell_r <= bell_nxt;
    end
  end

  // Power-up and return to origin
  logic [31:0] ptim_r, ptim_nxt;
  logic        pwr_r, pwr_nxt;
  always_comb begin
    ptim_nxt = ptim_r;
    pwr_nxt  = pwr_r;
    if (pwr_r) begin
      if (ptim_r >= PWRUP_CYC - 1) pwr_nxt = 1'b0;
      else ptim_nxt = ptim_r + 32'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptim_r <= '0;
      pwr_r  <= 1'b1;
    end else begin
      ptim_r <= ptim_nxt;
      pwr_r  <= pwr_nxt;
    end
  end

  kvb_out_s out_nxt;
  always_comb begin
    out_nxt.view_active        = (vst_r != KVB_HOLDING);
    out_nxt.dim_req_n          = (vst_r != KVB_HOLDING);
    out_nxt.watch_lamp_drive   = (vst_r == KVB_WARNING) & wcnt_r[0]
                               & (wcnt_r != `KVB_WCNT_FULL);
    out_nxt.repeat_char_strobe = strb_r;
    out_nxt.tone_p             = tone_r;
    out_nxt.tone_n             = ~tone_r;
    out_nxt.audio_out          = click_r | (bell_r & tone_r);
    out_nxt.power_up_pulse     = pwr_r;
    out_nxt.return_origin_n    = ~(pwr_r | sy.return_origin_key);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out <= '{view_active: 1'b1, dim_req_n: 1'b1, power_up_pulse: 1'b1,
               tone_n: 1'b1, default: 1'b0};
    end else begin
      out <= out_nxt;
    end
  end

  chk_dim_at_full: assert property (@(posedge clk) disable iff (!rst_n)
    (vst_r == KVB_WARNING && wcnt_r == 4'hf && !restart)
      |=> (vst_r == KVB_HOLDING) ##1 (!out.view_active && !out.dim_req_n))
    else $error("dim not asserted at full count");
  chk_restart_view: assert property (@(posedge clk) disable iff (!rst_n)
    restart |=> (vst_r == KVB_VIEWING && wcnt_r == 4'h0) ##1 out.view_active)
    else $error("restart did not resume viewing");
  chk_delay_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (vst_r == KVB_VIEWING) |-> (wcnt_r == 4'h0 && !wpulse_r))
    else $error("warning active during viewing delay");
  chk_cnt_step: assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(wcnt_r) && !$past(restart)) |-> $fell(wpulse_r)
      && wcnt_r == $past(wcnt_r) + 4'h1)
    else $error("counter moved without pulse end");
  chk_lamp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (vst_r == KVB_HOLDING) |=> !out.watch_lamp_drive)
    else $error("lamp on in hold");
  chk_lamp_full: assert property (@(posedge clk) disable iff (!rst_n)
    (wcnt_r == 4'hf) |=> !out.watch_lamp_drive)
    else $error("lamp lit at full count");
  chk_strobe_follow: assert property (@(posedge clk) disable iff (!rst_n)
    (!gate_r) |=> (strb_r == $past(sy.key_press_strobe)))
    else $error("strobe does not follow raw strobe");
  chk_click_len: assert property (@(posedge clk) disable iff (!rst_n)
    (strb_r && !strb_nxt) |=> click_r [*2])
    else $error("click too short");
  chk_bell_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (!bell_r && !click_r) |=> !out.audio_out)
    else $error("tone leaked without enable");
  chk_bell_start: assert property (@(posedge clk) disable iff (!rst_n)
    bell_rise |=> bell_r && btim_r == 32'h0)
    else $error("bell not started");
  chk_origin_key: assert property (@(posedge clk) disable iff (!rst_n)
    sy.return_origin_key |=> !out.return_origin_n)
    else $error("origin output not asserted");
  chk_edit_view: assert property (@(posedge clk) disable iff (!rst_n)
    sy.edit_mode [*3] |-> out.view_active)
    else $error("timeout in edit mode");

  cov_hold: cover property (@(posedge clk) disable iff (!rst_n)
    vst_r == KVB_HOLDING);
  cov_repeat: cover property (@(posedge clk) disable iff (!rst_n)
    sy.autorepeat_key && $rose(gate_r));
  cov_bell: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(bell_r));
  cov_pwr_end: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(pwr_r));
endmodule
`default_nettype wire

// ==== kvb_keys.sv ====
`timescale 1ns/1ps
`default_nettype none
module kvb_keys (
  input  wire logic             clk,  // Bench clock
  input  wire kvb_pkg::kvb_in_s req,  // Switch positions wanted
  output var  kvb_pkg::kvb_in_s in_a  // Switch levels to block
);
  import kvb_pkg::*;
  // Switches move only off the sampling edge
  always @(negedge clk) in_a <= req;
endmodule
`default_nettype wire

// ==== kvb_pkg.sv ====
package kvb_pkg;
  typedef enum logic [1:0] {
    KVB_VIEWING = 2'b00,
    KVB_WARNING = 2'b01,
    KVB_HOLDING = 2'b10
  } kvb_view_e;
  typedef struct packed {
    logic edit_mode;
    logic data_activity;
    logic watch_key;
    logic watch_restart;
    logic key_press_strobe;
    logic autorepeat_key;
    logic bell_command;
    logic ring_command;
    logic return_origin_key;
  } kvb_in_s;
  typedef struct packed {
    logic view_active;
    logic dim_req_n;
    logic watch_lamp_drive;
    logic repeat_char_strobe;
    logic audio_out;
    logic tone_p;
    logic tone_n;
    logic power_up_pulse;
    logic return_origin_n;
  } kvb_out_s;
endpackage

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import kvb_pkg::*;
  localparam int V = 200, W = 5, R = 20, C = 4, B = 30, T = 2, P = 10;
  logic     clk = 0, rst_n = 0;
  kvb_in_s  req = '0;
  kvb_in_s  in_a;
  kvb_out_s out;
  int       errors = 0, compares = 0, n, m;
  int       falls = 0, clicks = 0, blinks = 0, run = 0;
  logic     ps = 0, pa = 0;
  // Rows: strobe, origin key, strobe out, origin out (low active)
  logic [3:0] rows [4] = '{4'h1, 4'hb, 4'h4, 4'he};

  initial forever #2 clk = ~clk;

  kvb_keys keys (.clk(clk), .req(req), .in_a(in_a));
  kvb_ctrl #(.VIEW_CYC(V), .WARN_CYC(W), .RPT_CYC(R), .CLICK_CYC(C),
    .BELL_CYC(B), .TONE_CYC(T), .PWRUP_CYC(P)) uut (
    .clk(clk), .rst_n(rst_n), .in_a(in_a), .out(out));

  // Every lamp-on stretch counts, so a one-cycle flash shows up
  always @(posedge clk) begin
    ps <= out.repeat_char_strobe;
    pa <= out.audio_out;
    if (ps && !out.repeat_char_strobe) falls++;
    if (!pa && out.audio_out) clicks++;
    run = out.watch_lamp_drive ? run + 1 : 0;
    if (run == 1) blinks++;
  end

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic end_sim;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #40000;
    errors++;
    end_sim();
  end

  initial begin
    cyc(5);
    check(out.view_active, 1);
    check(out.dim_req_n, 1);
    check(out.power_up_pulse, 1);
    check(out.return_origin_n, 0);
    cyc(5);
    rst_n = 1;
    for (n = 0; n < 50 && out.power_up_pulse === 1; n++) cyc(1);
    check(n >= P && n <= P + 4, 1);
    cyc(4);
    check(out.return_origin_n, 1);
    for (int k = 0; k < 4; k++) begin
      req.key_press_strobe  = rows[k][3];
      req.return_origin_key = rows[k][2];
      cyc(8);
      check(out.repeat_char_strobe, rows[k][1]);
      check(out.return_origin_n, rows[k][0]);
      check(out.tone_p ^ out.tone_n, 1);
    end
    m = out.tone_p;
    cyc(T);
    check(out.tone_p ^ m[0], 1);
    req = '0;
    cyc(8);
    req.watch_key = 1;
    cyc(3);
    req.watch_key = 0;
    blinks = 0;
    for (n = 0; n < V + 400 && out.view_active === 1; n++) cyc(1);
    check(n >= V, 1);
    check(n <= V + 30 * W + 20, 1);
    check(blinks, 7);
    cyc(3);
    check(out.dim_req_n, 0);
    cyc(50);
    check(out.watch_lamp_drive, 0);
    check(blinks, 7);
    // Each restart source but edit mode, first from hold, then mid-warning
    for (int k = 0; k < 3; k++) begin
      cyc(V + 30);
      req[7-k] = 1;
      cyc(4);
      req[7-k] = 0;
      cyc(6);
      check(out.watch_lamp_drive, 0);
      check(out.view_active, 1);
      check(out.dim_req_n, 1);
    end
    req.edit_mode = 1;
    cyc(V + 250);
    check(out.view_active, 1);
    check(out.dim_req_n, 1);
    req.edit_mode = 0;
    cyc(10);
    falls = 0;
    clicks = 0;
    req.key_press_strobe = 1;
    req.autorepeat_key = 1;
    cyc(8 * R);
    req = '0;
    cyc(20);
    check(falls >= 4 && falls <= 6, 1);
    check(clicks, falls);
    for (int k = 0; k < 2; k++) begin
      clicks = 0;
      req[2-k] = 1;
      cyc(B / 2);
      check(clicks >= 2, 1);
      cyc(B + 10);
      m = clicks;
      cyc(20);
      check(clicks, m);
      req[2-k] = 0;
      cyc(5);
    end
    // Mid-run reset must restart the power-up pulse
    rst_n = 0;
    cyc(2);
    check(out.power_up_pulse, 1);
    check(out.return_origin_n, 0);
    check(out.view_active, 1);
    rst_n = 1;
    cyc(P + 4);
    check(out.power_up_pulse, 0);
    check(out.return_origin_n, 1);
    end_sim();
  end
endmodule
`default_nettype wire
